//--- hw/rbs_defines.svh
// Summary of operation
// - Reset input low holds all logic reset
// - Reset release starts selected boot mode
// - Three boot modes: host, emulation, ROM
// - Host boot stalls CPU, rest runs
// - Host port reads, writes memory while stalled
// - Host sets irq bit to end boot
// - Released CPU starts at address zero
// - Irq bit during stall not CPU-pending
// - Irq bit releases stall only non-ROM
// - No new irq until CPU clears bit
// - Emulator sets irq bit to release CPU
// - Emulator breakpoints address zero before release
// - ROM boot copies 1 KB to zero
// - ROM width 8/16 packed into words
// - Copy is one single-frame block transfer
// - Copy done releases CPU at zero
// - ROM content in system byte order
// - Power-up asserts core and test resets
// - Core and test resets act separately
// - Boot works with test reset held
// - Test reset pin pulled down internally
// - Test reset rise latches emulation pins, except in held state
// - Debug controller drives test reset high
`ifndef RBS_DEFINES_SVH
`define RBS_DEFINES_SVH

// Boot mode codes on the strap inputs
`define RBS_BOOT_HOST      2'h0
`define RBS_BOOT_EMU       2'h1
`define RBS_BOOT_ROM       2'h2

// ROM width codes
`define RBS_ROMW_8         2'h0
`define RBS_ROMW_16        2'h1
`define RBS_ROMW_32        2'h2

// Boot copy size and start address
`define RBS_BOOT_WORDS     256
`define RBS_START_ADDR     32'h0000_0000

// Host port address: bit 8 selects the control register
`define RBS_HP_CTRL_BIT    8
`define RBS_IRQ_BIT        0

// Host-end register byte offsets
`define RBS_REG_CTRL       8'h00
`define RBS_REG_HP_ADDR    8'h04
`define RBS_REG_HP_WDATA   8'h08
`define RBS_REG_HP_CMD     8'h0c
`define RBS_REG_HP_RDATA   8'h10
`define RBS_REG_ROM_PTR    8'h14
`define RBS_REG_ROM_DATA   8'h18

// CTRL fields and reset value
`define RBS_CTRL_CORE_RST  0
`define RBS_CTRL_TRST_HI   1
`define RBS_CTRL_EMU_LO    2
`define RBS_CTRL_EMU_HI    3
`define RBS_CTRL_RESET     4'h1

`endif

//--- hw/rbs_pkg.sv
`default_nettype none
package rbs_pkg;

  typedef enum logic [1:0] {ST_HELD, ST_STALL, ST_ROM_COPY, ST_RUN} rbs_state_e;

  typedef struct packed {
    rbs_state_e  state;
    logic [1:0]  boot_mode;
    logic [1:0]  rom_width;
    logic        host_to_cpu_irq_bit;
    logic        cpu_irq;
    logic        stall;
    logic        core_rst;
    logic        test_rst;
    logic        trst_q;
    logic [1:0]  emu_mode;
    logic        hp_ack;
    logic [31:0] hp_rdata;
    logic        rom_req;
    logic [9:0]  rom_addr;
    logic [31:0] word_acc;
    logic [31:0] start_addr;
  } rbs_dev_s;

  typedef struct packed {
    logic        wb_ack;
    logic [31:0] wb_dat;
    logic [3:0]  ctrl;
    logic [8:0]  hp_addr;
    logic [31:0] hp_wdata;
    logic        hp_we;
    logic        hp_req;
    logic [31:0] hp_rdata;
    logic [7:0]  rom_ptr;
    logic        rom_ack;
    logic [31:0] rom_rdata;
  } rbs_host_s;

endpackage
`default_nettype wire

//--- hw/rbs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rbs_link_if;
  logic        core_rst_n;
  logic        host_trst_out;
  logic        host_trst_oe;
  logic        trst;
  logic        emulation_config_pin_hi;
  logic        emulation_config_pin_lo;
  logic        hp_req;
  logic        hp_we;
  logic [8:0]  hp_addr;
  logic [31:0] hp_wdata;
  logic        hp_ack;
  logic [31:0] hp_rdata;
  logic        ext_space_one_select;
  logic [9:0]  rom_addr;
  logic [1:0]  rom_width;
  logic        rom_ack;
  logic [31:0] rom_rdata;

  // Undriven pin reads low, so test reset is asserted at power-up
  assign trst = host_trst_oe ? host_trst_out : 1'b0;

  modport dev (
    input  core_rst_n, trst, emulation_config_pin_hi,
           emulation_config_pin_lo, hp_req, hp_we, hp_addr, hp_wdata,
           rom_ack, rom_rdata,
    output hp_ack, hp_rdata, ext_space_one_select, rom_addr, rom_width
  );

  modport host (
    input  trst, hp_ack, hp_rdata, ext_space_one_select, rom_addr,
           rom_width,
    output core_rst_n, host_trst_out, host_trst_oe,
           emulation_config_pin_hi, emulation_config_pin_lo, hp_req,
           hp_we, hp_addr, hp_wdata, rom_ack, rom_rdata
  );
endinterface
`default_nettype wire

//--- hw/rbs_dev_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbs_defines.svh"
module rbs_dev_end #(
  parameter int MEM_WORDS = `RBS_BOOT_WORDS
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic [1:0]  BOOT_MODE_IN,
  input  wire logic [1:0]  ROM_WIDTH_IN,
  input  wire logic        CPU_CLR_IRQ_IN,
  output logic             CPU_STALL_OUT,
  output logic             CPU_IRQ_OUT,
  output logic [31:0]      CPU_START_ADDR_OUT,
  output logic             CORE_RST_OUT,
  output logic             TEST_RST_OUT,
  output logic [1:0]       EMU_MODE_OUT,
  output logic [1:0]       BOOT_MODE_OUT,
  rbs_link_if.dev          link
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  // Copy length and host port decode both assume exactly 1 KB
  if (MEM_WORDS != `RBS_BOOT_WORDS)
  begin : g_bad_words
    $error("rbs_dev_end: MEM_WORDS must be 256");
  end

  localparam rbs_pkg::rbs_dev_s DEV_RST = '{
    state: rbs_pkg::ST_HELD, stall: 1'b1, core_rst: 1'b1,
    test_rst: 1'b1, start_addr: `RBS_START_ADDR, default: '0};

  rbs_pkg::rbs_dev_s r_ff;
  rbs_pkg::rbs_dev_s nxt_r;
  logic [31:0]       mem [MEM_WORDS];
  logic              mem_we;
  logic [7:0]        mem_waddr;
  logic [31:0]       mem_wdata;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic        hp_take;
    logic        last_beat;
    logic [31:0] acc;
    logic [9:0]  step;
    hp_take   = 1'b0;
    last_beat = 1'b0;
    acc       = '0;
    step      = 10'h001;
    nxt_r     = r_ff;
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    nxt_r.cpu_irq = 1'b0;
    nxt_r.hp_ack  = 1'b0;

    // Test side runs from its own pin; only the emulation pin latch waits out the held state
    nxt_r.trst_q   = link.trst;
    nxt_r.test_rst = !link.trst;
    if (link.trst && !r_ff.trst_q && r_ff.state != rbs_pkg::ST_HELD)
    begin
      nxt_r.emu_mode = {link.emulation_config_pin_hi,
                        link.emulation_config_pin_lo};
    end

    // Set below wins over this clear
    if (CPU_CLR_IRQ_IN)
    begin
      nxt_r.host_to_cpu_irq_bit = 1'b0;
    end

    unique case (r_ff.state)
      rbs_pkg::ST_HELD:
      begin
        nxt_r.core_rst  = 1'b0;
        nxt_r.boot_mode = BOOT_MODE_IN;
        nxt_r.rom_width = ROM_WIDTH_IN;
        if (BOOT_MODE_IN == `RBS_BOOT_ROM)
        begin
          nxt_r.state    = rbs_pkg::ST_ROM_COPY;
          nxt_r.rom_req  = 1'b1;
          nxt_r.rom_addr = '0;
          nxt_r.word_acc = '0;
        end
        else
        begin
          // Host, emulation, and the spare code all wait for the host
          nxt_r.state = rbs_pkg::ST_STALL;
        end
      end
      rbs_pkg::ST_ROM_COPY:
      begin
        if (link.rom_ack)
        begin
          acc = r_ff.word_acc;
          if (r_ff.rom_width == `RBS_ROMW_8)
          begin
            acc[8*r_ff.rom_addr[1:0] +: 8] = link.rom_rdata[7:0];
            last_beat = (r_ff.rom_addr[1:0] == 2'h3);
            step      = 10'h001;
          end
          else if (r_ff.rom_width == `RBS_ROMW_16)
          begin
            acc[16*r_ff.rom_addr[1] +: 16] = link.rom_rdata[15:0];
            last_beat = r_ff.rom_addr[1];
            step      = 10'h002;
          end
          else
          begin
            acc       = link.rom_rdata;
            last_beat = 1'b1;
            step      = 10'h004;
          end
          nxt_r.word_acc = acc;
          nxt_r.rom_addr = r_ff.rom_addr + step;
          if (last_beat)
          begin
            mem_we    = 1'b1;
            mem_waddr = r_ff.rom_addr[9:2];
            mem_wdata = acc;
            if (r_ff.rom_addr[9:2] == 8'hff)
            begin
              // One frame, one pass: the end of it frees the CPU
              nxt_r.rom_req    = 1'b0;
              nxt_r.state      = rbs_pkg::ST_RUN;
              nxt_r.stall      = 1'b0;
              nxt_r.start_addr = `RBS_START_ADDR;
            end
          end
        end
      end
      rbs_pkg::ST_STALL,
      rbs_pkg::ST_RUN:
      begin
        // Host port is live in both; guard stops a held request
        hp_take = link.hp_req && !r_ff.hp_ack;
      end
    endcase

    if (hp_take)
    begin
      nxt_r.hp_ack = 1'b1;
      if (link.hp_addr[`RBS_HP_CTRL_BIT])
      begin
        nxt_r.hp_rdata = {31'h0, r_ff.host_to_cpu_irq_bit};
        if (link.hp_we && link.hp_wdata[`RBS_IRQ_BIT] &&
            !r_ff.host_to_cpu_irq_bit)
        begin
          nxt_r.host_to_cpu_irq_bit = 1'b1;
          // Only a running CPU sees it as an interrupt
          nxt_r.cpu_irq = (r_ff.state == rbs_pkg::ST_RUN);
          if (r_ff.state == rbs_pkg::ST_STALL &&
              r_ff.boot_mode != `RBS_BOOT_ROM)
          begin
            nxt_r.state      = rbs_pkg::ST_RUN;
            nxt_r.stall      = 1'b0;
            nxt_r.start_addr = `RBS_START_ADDR;
          end
        end
      end
      else
      begin
        nxt_r.hp_rdata = mem[link.hp_addr[7:0]];
        if (link.hp_we)
        begin
          mem_we    = 1'b1;
          mem_waddr = link.hp_addr[7:0];
          mem_wdata = link.hp_wdata;
        end
      end
    end

    // Core reset pin: back to held, test side keeps its state
    if (!link.core_rst_n)
    begin
      nxt_r.state               = rbs_pkg::ST_HELD;
      nxt_r.stall               = 1'b1;
      nxt_r.core_rst            = 1'b1;
      nxt_r.host_to_cpu_irq_bit = 1'b0;
      nxt_r.cpu_irq             = 1'b0;
      nxt_r.hp_ack              = 1'b0;
      nxt_r.rom_req             = 1'b0;
      nxt_r.start_addr          = `RBS_START_ADDR;
      mem_we                    = 1'b0;
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      r_ff <= DEV_RST;
    end
    else if (CE_IN)
    begin
      r_ff <= nxt_r;
    end
  end

  // Boot image store, no reset: contents come from host or ROM
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (CE_IN && mem_we)
    begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign CPU_STALL_OUT             = r_ff.stall;
  assign CPU_IRQ_OUT               = r_ff.cpu_irq;
  assign CPU_START_ADDR_OUT        = r_ff.start_addr;
  assign CORE_RST_OUT              = r_ff.core_rst;
  assign TEST_RST_OUT              = r_ff.test_rst;
  assign EMU_MODE_OUT              = r_ff.emu_mode;
  assign BOOT_MODE_OUT             = r_ff.boot_mode;
  assign link.hp_ack               = r_ff.hp_ack;
  assign link.hp_rdata             = r_ff.hp_rdata;
  assign link.ext_space_one_select = r_ff.rom_req;
  assign link.rom_addr             = r_ff.rom_addr;
  assign link.rom_width            = r_ff.rom_width;

endmodule // rbs_dev_end
`default_nettype wire

//--- hw/rbs_host_end.sv
`timescale 1ns/1ps
`default_nettype none
`include "rbs_defines.svh"
module rbs_host_end #(
  parameter int ROM_WORDS = `RBS_BOOT_WORDS
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  rbs_link_if.host         link
);

  if (ROM_WORDS != `RBS_BOOT_WORDS)
  begin : g_bad_words
    $error("rbs_host_end: ROM_WORDS must be 256");
  end

  localparam rbs_pkg::rbs_host_s HOST_RST = '{
    ctrl: `RBS_CTRL_RESET, default: '0};

  rbs_pkg::rbs_host_s r_ff;
  rbs_pkg::rbs_host_s nxt_r;
  logic [31:0]        rom_mem [ROM_WORDS];
  logic               rom_we;
  logic [31:0]        wmask;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic        take;
    logic [31:0] word;
    take   = WB_CYC_IN && WB_STB_IN && !r_ff.wb_ack;
    word   = rom_mem[link.rom_addr[9:2]];
    nxt_r  = r_ff;
    rom_we = 1'b0;
    wmask  = {{8{WB_SEL_IN[3]}}, {8{WB_SEL_IN[2]}},
              {8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};
    nxt_r.wb_ack  = take;
    nxt_r.rom_ack = 1'b0;

    if (take)
    begin
      nxt_r.wb_dat = '0;
      unique case (WB_ADR_IN)
        `RBS_REG_CTRL:
        begin
          nxt_r.wb_dat = {28'h0, r_ff.ctrl};
          if (WB_WE_IN && WB_SEL_IN[0])
          begin
            nxt_r.ctrl = WB_DAT_IN[3:0];
          end
        end
        `RBS_REG_HP_ADDR:
        begin
          nxt_r.wb_dat = {23'h0, r_ff.hp_addr};
          if (WB_WE_IN)
          begin
            nxt_r.hp_addr = 9'((WB_DAT_IN & wmask) |
                               ({23'h0, r_ff.hp_addr} & ~wmask));
          end
        end
        `RBS_REG_HP_WDATA:
        begin
          nxt_r.wb_dat = r_ff.hp_wdata;
          if (WB_WE_IN)
          begin
            nxt_r.hp_wdata = (WB_DAT_IN & wmask) | (r_ff.hp_wdata & ~wmask);
          end
        end
        `RBS_REG_HP_CMD:
        begin
          nxt_r.wb_dat = {31'h0, r_ff.hp_req};
          // A command while one is in flight is dropped
          if (WB_WE_IN && WB_SEL_IN[0] && !r_ff.hp_req)
          begin
            nxt_r.hp_we  = WB_DAT_IN[0];
            nxt_r.hp_req = 1'b1;
          end
        end
        `RBS_REG_HP_RDATA:
        begin
          nxt_r.wb_dat = r_ff.hp_rdata;
        end
        `RBS_REG_ROM_PTR:
        begin
          nxt_r.wb_dat = {24'h0, r_ff.rom_ptr};
          if (WB_WE_IN && WB_SEL_IN[0])
          begin
            nxt_r.rom_ptr = WB_DAT_IN[7:0];
          end
        end
        `RBS_REG_ROM_DATA:
        begin
          nxt_r.wb_dat = rom_mem[r_ff.rom_ptr];
          if (WB_WE_IN)
          begin
            // Image loaded in the system byte order, word by word
            rom_we        = 1'b1;
            nxt_r.rom_ptr = r_ff.rom_ptr + 8'h01;
          end
        end
        default:
        begin
          nxt_r.wb_dat = '0;
        end
      endcase
    end

    if (r_ff.hp_req && link.hp_ack)
    begin
      nxt_r.hp_req   = 1'b0;
      nxt_r.hp_rdata = link.hp_rdata;
    end

    // ROM answers one cycle after a fresh request
    if (link.ext_space_one_select && !r_ff.rom_ack)
    begin
      nxt_r.rom_ack = 1'b1;
      if (link.rom_width == `RBS_ROMW_8)
      begin
        nxt_r.rom_rdata = {24'h0, word[8*link.rom_addr[1:0] +: 8]};
      end
      else if (link.rom_width == `RBS_ROMW_16)
      begin
        nxt_r.rom_rdata = {16'h0, word[16*link.rom_addr[1] +: 16]};
      end
      else
      begin
        nxt_r.rom_rdata = word;
      end
    end
  end

  // ************************************************************
  // State registers
  // ************************************************************
  always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      r_ff <= HOST_RST;
    end
    else if (CE_IN)
    begin
      r_ff <= nxt_r;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (CE_IN && rom_we)
    begin
      rom_mem[r_ff.rom_ptr] <= (WB_DAT_IN & wmask) |
                               (rom_mem[r_ff.rom_ptr] & ~wmask);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign WB_ACK_OUT                   = r_ff.wb_ack;
  assign WB_DAT_OUT                   = r_ff.wb_dat;
  assign link.core_rst_n              = !r_ff.ctrl[`RBS_CTRL_CORE_RST];
  assign link.host_trst_out           = r_ff.ctrl[`RBS_CTRL_TRST_HI];
  assign link.host_trst_oe            = r_ff.ctrl[`RBS_CTRL_TRST_HI];
  assign link.emulation_config_pin_lo = r_ff.ctrl[`RBS_CTRL_EMU_LO];
  assign link.emulation_config_pin_hi = r_ff.ctrl[`RBS_CTRL_EMU_HI];
  assign link.hp_req                  = r_ff.hp_req;
  assign link.hp_we                   = r_ff.hp_we;
  assign link.hp_addr                 = r_ff.hp_addr;
  assign link.hp_wdata                = r_ff.hp_wdata;
  assign link.rom_ack                 = r_ff.rom_ack;
  assign link.rom_rdata               = r_ff.rom_rdata;

endmodule // rbs_host_end
`default_nettype wire

//--- dv/rbs_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rbs_link_asserts (
  input wire logic       CLK_SYS_IN,
  input wire logic       ARST_N_IN,
  input wire logic       core_rst_n,
  input wire logic       host_trst_oe,
  input wire logic       trst,
  input wire logic       hp_req,
  input wire logic       hp_ack,
  input wire logic       ext_space_one_select,
  input wire logic [9:0] rom_addr,
  input wire logic [1:0] rom_width,
  input wire logic       rom_ack
);
  logic [9:0] beat_next;

  // Wraps to zero after the last beat of the copy
  assign beat_next = rom_addr + ((rom_width == 2'h0) ? 10'h1 :
                                 (rom_width == 2'h1) ? 10'h2 : 10'h4);

  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  // ****************************************
  // Link properties
  // ****************************************
  property p_trst_pulldown;
    !host_trst_oe |-> !trst;
  endproperty
  a_trst_pulldown: assert property (p_trst_pulldown)
    else $error("test reset not low while undriven");

  property p_hp_ack_pulse;
    hp_ack |=> !hp_ack;
  endproperty
  a_hp_ack_pulse: assert property (p_hp_ack_pulse)
    else $error("host port ack wider than one cycle");

  property p_hp_ack_cause;
    hp_ack |-> $past(hp_req);
  endproperty
  a_hp_ack_cause: assert property (p_hp_ack_cause)
    else $error("host port ack without request");

  property p_rom_hold;
    ext_space_one_select && !rom_ack |=>
      ext_space_one_select && $stable(rom_addr);
  endproperty
  a_rom_hold: assert property (p_rom_hold)
    else $error("rom request changed before ack");

  property p_rom_step;
    ext_space_one_select && rom_ack && beat_next != 10'h0 |=>
      ext_space_one_select && rom_addr == $past(beat_next);
  endproperty
  a_rom_step: assert property (p_rom_step)
    else $error("rom address step wrong for width");

  property p_rom_last;
    ext_space_one_select && rom_ack && beat_next == 10'h0 |=>
      ##[0:2] !ext_space_one_select;
  endproperty
  a_rom_last: assert property (p_rom_last)
    else $error("rom request not dropped after last beat");

  property p_width_stable;
    ext_space_one_select && $past(ext_space_one_select) |->
      $stable(rom_width);
  endproperty
  a_width_stable: assert property (p_width_stable)
    else $error("rom width changed during copy");

  property p_held_no_rom;
    !core_rst_n |=> !ext_space_one_select;
  endproperty
  a_held_no_rom: assert property (p_held_no_rom)
    else $error("rom request during core reset");

  property p_held_no_hp;
    !core_rst_n [*2] |=> !hp_ack;
  endproperty
  a_held_no_hp: assert property (p_held_no_hp)
    else $error("host port answered during core reset");

  c_rom_done: cover property ($fell(ext_space_one_select));
  c_hp_ack: cover property (hp_ack);
  c_trst_rise: cover property ($rose(trst));
endmodule // rbs_link_asserts
`default_nettype wire

//--- dv/reset_and_boot_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    num_checks++; \
    if ((a) !== (b)) begin bad_count++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (b)); end \
  end
module reset_and_boot_sequencer_test;
  logic        clk_sys, arst_n, ce, cpu_clr, cyc, stb, we, ack;
  logic [1:0]  boot_mode, rom_width, emu_mode, boot_out;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, start_addr;
  logic        stall, irq, core_rst, test_rst;
  int          bad_count, num_checks, irq_n, beats, n;

  rbs_link_if rbs_link_if_i ();
  rbs_dev_end rbs_dev_end_i (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n), .CE_IN(ce),
    .BOOT_MODE_IN(boot_mode), .ROM_WIDTH_IN(rom_width),
    .CPU_CLR_IRQ_IN(cpu_clr), .CPU_STALL_OUT(stall), .CPU_IRQ_OUT(irq),
    .CPU_START_ADDR_OUT(start_addr), .CORE_RST_OUT(core_rst),
    .TEST_RST_OUT(test_rst), .EMU_MODE_OUT(emu_mode),
    .BOOT_MODE_OUT(boot_out), .link(rbs_link_if_i));
  rbs_host_end rbs_host_end_i (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n), .CE_IN(ce),
    .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr),
    .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .link(rbs_link_if_i));
  rbs_link_asserts rbs_link_asserts_i (
    .CLK_SYS_IN(clk_sys), .ARST_N_IN(arst_n),
    .core_rst_n(rbs_link_if_i.core_rst_n),
    .host_trst_oe(rbs_link_if_i.host_trst_oe),
    .trst(rbs_link_if_i.trst), .hp_req(rbs_link_if_i.hp_req),
    .hp_ack(rbs_link_if_i.hp_ack),
    .ext_space_one_select(rbs_link_if_i.ext_space_one_select),
    .rom_addr(rbs_link_if_i.rom_addr), .rom_width(rbs_link_if_i.rom_width),
    .rom_ack(rbs_link_if_i.rom_ack));

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    if (irq === 1'b1) irq_n++;
    if (rbs_link_if_i.rom_ack === 1'b1) beats++;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  function automatic logic [31:0] pat(input int i);
    return 32'h5a00_c300 ^ (32'(i) * 32'h0001_0103);
  endfunction

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    // Only the watchdog ends a wait for the answer
    @(posedge clk_sys);
    while (ack !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Host port access through the bridge, polled until not busy
  task automatic hp(input logic w, input logic [8:0] a, input logic [31:0] d);
    int k;
    wb(1'b1, 8'h04, 32'(a));
    wb(1'b1, 8'h08, d);
    wb(1'b1, 8'h0c, 32'(w));
    k = 0;
    do
    begin
      wb(1'b0, 8'h0c, 32'h0);
      k++;
    end
    while (q[0] !== 1'b0 && k < 20);
    if (k >= 20) bad_count++;
    wb(1'b0, 8'h10, 32'h0);
  endtask

  task automatic boot(input logic [1:0] m, input logic [1:0] w);
    wb(1'b1, 8'h00, 32'h1);
    boot_mode <= m;
    rom_width <= w;
    beats = 0;
    wb(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run is near 5k cycles; this allows about six times that
  initial
  begin
    #3_000_000;
    bad_count++;
    results();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {clk_sys, arst_n, cpu_clr, cyc, stb, we, boot_mode, rom_width} = '0;
    {adr, wdat, bad_count, num_checks, irq_n, beats} = '0;
    ce = 1'b1;
    sel = 4'hf;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(stall, 1'b1)
    `CHK(core_rst, 1'b1)
    `CHK(test_rst, 1'b1)
    `CHK(irq, 1'b0)
    @(posedge clk_sys);
    arst_n <= 1'b1;
    wb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h1)
    wb(1'b0, 8'h1c, 32'h0);
    `CHK(q, 32'h0)
    `CHK(rbs_link_if_i.trst, 1'b0)
    `CHK(core_rst, 1'b1)
    wb(1'b1, 8'h14, 32'h0);
    for (int i = 0; i < 256; i++) wb(1'b1, 8'h18, pat(i));
    boot(2'h0, 2'h0);
    `CHK(core_rst, 1'b0)
    `CHK(stall, 1'b1)
    `CHK(test_rst, 1'b1)
    `CHK(boot_out, 2'h0)
    hp(1'b1, 9'h007, 32'hdead_beef);
    hp(1'b0, 9'h007, 32'h0);
    `CHK(q, 32'hdead_beef)
    boot_mode <= 2'h2;
    hp(1'b1, 9'h100, 32'h1);
    `CHK(stall, 1'b0)
    `CHK(start_addr, 32'h0)
    `CHK(irq_n, 0)
    `CHK(boot_out, 2'h0)
    hp(1'b1, 9'h100, 32'h1);
    `CHK(irq_n, 0)
    @(posedge clk_sys);
    cpu_clr <= 1'b1;
    @(posedge clk_sys);
    cpu_clr <= 1'b0;
    hp(1'b1, 9'h100, 32'h1);
    repeat (2) @(posedge clk_sys);
    `CHK(irq_n, 1)
    $display("host boot test done");
    boot(2'h1, 2'h0);
    `CHK(stall, 1'b1)
    `CHK(boot_out, 2'h1)
    wb(1'b1, 8'h00, 32'h6);
    repeat (3) @(posedge clk_sys);
    `CHK(emu_mode, 2'h1)
    `CHK(test_rst, 1'b0)
    `CHK(rbs_link_if_i.trst, 1'b1)
    wb(1'b1, 8'h00, 32'h0);
    repeat (3) @(posedge clk_sys);
    `CHK(test_rst, 1'b1)
    wb(1'b1, 8'h00, 32'ha);
    repeat (3) @(posedge clk_sys);
    `CHK(emu_mode, 2'h2)
    `CHK(stall, 1'b1)
    hp(1'b1, 9'h100, 32'h1);
    `CHK(stall, 1'b0)
    `CHK(start_addr, 32'h0)
    `CHK(irq_n, 1)
    $display("emulation boot test done");
    for (int w = 0; w < 3; w++)
    begin
      // Wipe the sampled words so each width must rewrite them
      for (int k = 0; k < 256; k += 85) hp(1'b1, 9'(k), 32'h0);
      boot(2'h2, 2'(w));
      `CHK(stall, 1'b1)
      n = 0;
      while (stall !== 1'b0 && n < 5000)
      begin
        @(posedge clk_sys);
        n++;
      end
      if (n >= 5000) bad_count++;
      `CHK(beats, 1024 >> w)
      `CHK(start_addr, 32'h0)
      `CHK(boot_out, 2'h2)
      for (int k = 0; k < 256; k += 85)
      begin
        hp(1'b0, 9'(k), 32'h0);
        `CHK(q, pat(k))
      end
    end
    $display("rom boot test done");
    results();
  end
endmodule // reset_and_boot_sequencer_test
`default_nettype wire
